// [rtl/vpl_lane_logic.sv]
// predicated lane control: register files, length limit, merge/zero write, gather/scatter walk
// assumes issue logic and memory port on the same clock; no pins from other domains
// How it works
// [RL1] vector width is a multiple of 128 bits, from 128 to 2048
// [RL2] each operation picks element size 8, 16, 32, 64 or 128 bits
// [RL3] predicate registers hold one bit per vector byte
// [RL4] predicate element width is one eighth of the vector element width
// [RL5] a predicate element is true when its lowest bit is one
// [RL6] upper predicate element bits ignored on read, written as zero
// [RL7] canonical predicate: only element lowest bits may be set
// [RL8] element zero sits at the least significant bits
// [RL9] only elements with a true governing predicate take part
// [RL10] with no governing predicate every element is active
// [RL11] merging keeps old contents in inactive destination elements
// [RL12] zeroing clears inactive destination elements
// [RL13] first active element is the lowest true element
// [RL14] last active element is the highest true element
// [RL15] destructive form writes the result over the first source
// [RL16] constructive form writes a separate destination, sources untouched
// [RL17] usable width limited by the length limits of the current level
// [RL18] one common vector length for all registers
// [RL19] gather fills elements from separately addressed memory reads
// [RL20] scatter writes each element to its own address
// [RL21] only predicate registers 0 to 7 may govern an operation
// [RL22] lane mask replicates each element's lowest predicate bit across its bytes
module vpl_lane_logic #(
    parameter int MAX_VL = vpl_pkg::MAX_VL_BITS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [vpl_pkg::LEN_W-1:0] length_limit_level1,
    input wire logic [vpl_pkg::LEN_W-1:0] length_limit_level2,
    input wire logic [vpl_pkg::LEN_W-1:0] length_limit_level3,
    input wire logic [vpl_pkg::LEVEL_W-1:0] cur_level,
    input wire logic op_valid,
    input wire vpl_pkg::vpl_op_t op_kind,
    input wire vpl_pkg::vpl_esize_t op_esize,
    input wire vpl_pkg::vpl_pmode_t op_pmode,
    input wire logic [vpl_pkg::PREG_IDX_W-1:0] op_gov_idx,
    input wire logic op_destructive,
    input wire logic [vpl_pkg::VREG_IDX_W-1:0] op_src_a,
    input wire logic [vpl_pkg::VREG_IDX_W-1:0] op_src_b,
    input wire logic [vpl_pkg::VREG_IDX_W-1:0] op_dst,
    input wire logic [MAX_VL-1:0] op_result,
    input wire logic [vpl_pkg::ADDR_W-1:0] op_base_addr,
    input wire logic mem_ack,
    input wire logic [vpl_pkg::ELEM_MAX_BITS-1:0] mem_rdata,
    input wire logic [vpl_pkg::VREG_IDX_W-1:0] rd_a_idx,
    input wire logic [vpl_pkg::VREG_IDX_W-1:0] rd_b_idx,
    input wire logic [vpl_pkg::PREG_IDX_W-1:0] rd_p_idx,
    output logic op_ready_r,
    output logic op_done_r,
    output logic op_err_r,
    output logic [$clog2(MAX_VL+1)-1:0] vector_length_r,
    output logic [$clog2(MAX_VL/8)-1:0] first_elem_r,
    output logic [$clog2(MAX_VL/8)-1:0] last_elem_r,
    output logic any_active_r,
    output logic mem_req_r,
    output logic mem_we_r,
    output logic [vpl_pkg::ADDR_W-1:0] mem_addr_r,
    output logic [vpl_pkg::ELEM_MAX_BITS-1:0] mem_wdata_r,
    output logic [MAX_VL-1:0] rd_a_data_r,
    output logic [MAX_VL-1:0] rd_b_data_r,
    output logic [MAX_VL/8-1:0] rd_p_data_r
);
    localparam int VB = MAX_VL / 8;
    localparam int IW = $clog2(VB);
    localparam int VLW = $clog2(MAX_VL + 1);
    localparam int BW = $clog2(VB + 1);
    localparam int MAX_GRAN = MAX_VL / vpl_pkg::GRANULE_BITS;
    localparam int EW = vpl_pkg::ELEM_MAX_BITS;

    if (MAX_VL % vpl_pkg::GRANULE_BITS != 0 || MAX_VL < vpl_pkg::MIN_VL_BITS
        || MAX_VL > vpl_pkg::MAX_VL_BITS)
    begin : g_bad_width
        $error("vector width must be a 128-bit multiple in 128..2048"); // RL1
    end

    typedef enum {ST_IDLE, ST_EXEC, ST_MEM} vpl_state_t;

    // element access, element zero at the low bytes
    function automatic logic [EW-1:0] get_elem(input logic [MAX_VL-1:0] v, input int e, input int sh);
        logic [EW-1:0] r;
        r = '0;
        for (int b = 0; b < VB; b++)
        begin
            if ((b >> sh) == e)
            begin
                r[8*(b-(e<<sh)) +: 8] = v[8*b +: 8]; // RL8
            end
        end
        return r;
    endfunction

    function automatic logic [MAX_VL-1:0] put_elem(input logic [MAX_VL-1:0] v, input int e, input int sh,
                                                   input logic [EW-1:0] d);
        logic [MAX_VL-1:0] r;
        r = v;
        for (int b = 0; b < VB; b++)
        begin
            if ((b >> sh) == e)
            begin
                r[8*b +: 8] = d[8*(b-(e<<sh)) +: 8];
            end
        end
        return r;
    endfunction

    function automatic int min_len(input int a, input int b);
        return (a < b) ? a : b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // register files; storage only, no reset so they map onto arrays
    logic [MAX_VL-1:0] vregs [vpl_pkg::NUM_VREGS];
    logic [VB-1:0] pregs [vpl_pkg::NUM_PREGS]; // RL3
    logic vwe;
    logic pwe;
    logic [MAX_VL-1:0] vwd;
    logic [VB-1:0] pwd;
    logic [vpl_pkg::VREG_IDX_W-1:0] wr_dst;

    always_ff @(posedge clock)
    begin
        if (vwe)
        begin
            vregs[wr_dst] <= vwd;
        end
        if (pwe)
        begin
            pregs[wr_dst[vpl_pkg::PREG_IDX_W-1:0]] <= pwd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // vector length from the level limits and read ports
    logic [VLW-1:0] vl_nxt;
    logic [MAX_VL-1:0] rd_a_nxt;
    logic [MAX_VL-1:0] rd_b_nxt;
    logic [VB-1:0] rd_p_nxt;

    always_comb
    begin
        int g;
        g = int'(length_limit_level3) + 1;
        if (cur_level != vpl_pkg::LEVEL3)
        begin
            g = min_len(g, int'(length_limit_level2) + 1);
        end
        if (cur_level < vpl_pkg::LEVEL2)
        begin
            g = min_len(g, int'(length_limit_level1) + 1);
        end
        // every 128-bit multiple is supported, so only the ceiling rounds down
        g = min_len(g, MAX_GRAN);
        vl_nxt = VLW'(g * vpl_pkg::GRANULE_BITS); // RL17 RL18
        rd_a_nxt = vregs[rd_a_idx];
        rd_b_nxt = vregs[rd_b_idx];
        rd_p_nxt = pregs[rd_p_idx];
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vector_length_r <= VLW'(vpl_pkg::MIN_VL_BITS);
            rd_a_data_r <= '0;
            rd_b_data_r <= '0;
            rd_p_data_r <= '0;
        end
        else
        begin
            vector_length_r <= vl_nxt;
            rd_a_data_r <= rd_a_nxt;
            rd_b_data_r <= rd_b_nxt;
            rd_p_data_r <= rd_p_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // operation control
    vpl_state_t state_r, state_nxt;
    vpl_pkg::vpl_op_t kind_r, kind_nxt;
    vpl_pkg::vpl_esize_t esize_r, esize_nxt;
    vpl_pkg::vpl_pmode_t pmode_r, pmode_nxt;
    logic [vpl_pkg::PREG_IDX_W-1:0] gov_r, gov_nxt;
    logic [vpl_pkg::VREG_IDX_W-1:0] src_a_r, src_a_nxt, src_b_r, src_b_nxt, dst_r, dst_nxt;
    logic [MAX_VL-1:0] res_r, res_nxt, buf_r, buf_nxt;
    logic [vpl_pkg::ADDR_W-1:0] base_r, base_nxt, mem_addr_nxt;
    logic [IW:0] elem_r, elem_nxt;
    logic [IW-1:0] first_nxt, last_nxt, lm_first, lm_last;
    logic ready_nxt, done_nxt, err_nxt, any_nxt, req_nxt, we_nxt, lm_any;
    logic [EW-1:0] wdata_nxt;
    logic [VB-1:0] lm_mask, lm_base;
    logic [BW-1:0] vl_bytes;

    assign vl_bytes = BW'(vector_length_r >> 3);

    vpl_lane_mask #(.MAX_VL(MAX_VL)) u_mask (
        .gov_pred(pregs[gov_r]),
        .esize(esize_r),
        .vl_bytes(vl_bytes),
        .unpredicated(pmode_r == vpl_pkg::PM_NONE),
        .byte_mask(lm_mask),
        .elem_base(lm_base),
        .first_elem(lm_first),
        .last_elem(lm_last),
        .any_active(lm_any)
    );

    always_comb
    begin
        int sh;
        logic [MAX_VL-1:0] old_v;
        logic [VB-1:0] old_p;
        logic zero;
        sh = vpl_pkg::esize_shift(esize_r); // RL2
        old_v = vregs[dst_r];
        old_p = pregs[dst_r[vpl_pkg::PREG_IDX_W-1:0]];
        zero = (pmode_r == vpl_pkg::PM_ZERO);
        state_nxt = state_r;
        kind_nxt = kind_r;
        esize_nxt = esize_r;
        pmode_nxt = pmode_r;
        gov_nxt = gov_r;
        src_a_nxt = src_a_r;
        src_b_nxt = src_b_r;
        dst_nxt = dst_r;
        res_nxt = res_r;
        buf_nxt = buf_r;
        base_nxt = base_r;
        elem_nxt = elem_r;
        first_nxt = first_elem_r;
        last_nxt = last_elem_r;
        any_nxt = any_active_r;
        ready_nxt = op_ready_r;
        done_nxt = 1'b0;
        err_nxt = 1'b0;
        req_nxt = mem_req_r;
        we_nxt = mem_we_r;
        mem_addr_nxt = mem_addr_r;
        wdata_nxt = mem_wdata_r;
        vwe = 1'b0;
        pwe = 1'b0;
        vwd = '0;
        pwd = '0;
        wr_dst = dst_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (op_valid && op_pmode != vpl_pkg::PM_NONE
                    && int'(op_gov_idx) >= vpl_pkg::NUM_GOV_PREGS)
                begin
                    err_nxt = 1'b1; // RL21
                end
                else if (op_valid)
                begin
                    kind_nxt = op_kind;
                    esize_nxt = op_esize;
                    pmode_nxt = op_pmode;
                    gov_nxt = op_gov_idx;
                    src_a_nxt = op_src_a;
                    src_b_nxt = op_src_b;
                    dst_nxt = op_destructive ? op_src_a : op_dst; // RL15 RL16
                    res_nxt = op_result;
                    base_nxt = op_base_addr;
                    ready_nxt = 1'b0;
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                first_nxt = lm_first;
                last_nxt = lm_last;
                any_nxt = lm_any;
                for (int b = 0; b < VB; b++)
                begin
                    if (b >= int'(vl_bytes))
                    begin
                        vwd[8*b +: 8] = '0;
                        pwd[b] = 1'b0;
                    end
                    else if (lm_mask[b])
                    begin
                        vwd[8*b +: 8] = res_r[8*b +: 8]; // RL9
                        pwd[b] = res_r[b] & lm_base[b]; // RL6 RL7
                    end
                    else
                    begin
                        vwd[8*b +: 8] = zero ? 8'h00 : old_v[8*b +: 8]; // RL11 RL12
                        pwd[b] = zero ? 1'b0 : old_p[b] & lm_base[b]; // RL11 RL12 RL7
                    end
                end
                unique case (kind_r)
                    vpl_pkg::OP_VEC, vpl_pkg::OP_PRED:
                    begin
                        vwe = (kind_r == vpl_pkg::OP_VEC);
                        pwe = (kind_r == vpl_pkg::OP_PRED);
                        done_nxt = 1'b1;
                        ready_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                    vpl_pkg::OP_GATHER, vpl_pkg::OP_SCATTER:
                    begin
                        elem_nxt = '0;
                        buf_nxt = zero ? '0 : old_v;
                        state_nxt = ST_MEM;
                    end
                endcase
            end
            ST_MEM:
            begin
                if (mem_req_r)
                begin
                    if (mem_ack)
                    begin
                        req_nxt = 1'b0;
                        we_nxt = 1'b0;
                        elem_nxt = elem_r + 1'b1;
                        if (kind_r == vpl_pkg::OP_GATHER)
                        begin
                            buf_nxt = put_elem(buf_r, int'(elem_r), sh, mem_rdata); // RL19
                        end
                    end
                end
                else if (!any_active_r || elem_r > {1'b0, last_elem_r})
                begin
                    // elements past vector length are zeroed here as the buffer is written back
                    if (kind_r == vpl_pkg::OP_GATHER)
                    begin
                        vwe = 1'b1;
                        for (int b = 0; b < VB; b++)
                        begin
                            vwd[8*b +: 8] = (b < int'(vl_bytes)) ? buf_r[8*b +: 8] : 8'h00;
                        end
                    end
                    done_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
                else if (lm_mask[int'(elem_r) << sh])
                begin
                    req_nxt = 1'b1;
                    we_nxt = (kind_r == vpl_pkg::OP_SCATTER); // RL20
                    mem_addr_nxt = base_r + vpl_pkg::ADDR_W'(get_elem(vregs[src_b_r], int'(elem_r), sh));
                    wdata_nxt = get_elem(vregs[src_a_r], int'(elem_r), sh);
                end
                else
                begin
                    elem_nxt = elem_r + 1'b1; // RL9
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            kind_r <= vpl_pkg::OP_VEC;
            esize_r <= vpl_pkg::ES_B8;
            pmode_r <= vpl_pkg::PM_NONE;
            gov_r <= '0;
            src_a_r <= '0;
            src_b_r <= '0;
            dst_r <= '0;
            res_r <= '0;
            buf_r <= '0;
            base_r <= '0;
            elem_r <= '0;
            first_elem_r <= '0;
            last_elem_r <= '0;
            any_active_r <= 1'b0;
            op_ready_r <= 1'b1;
            op_done_r <= 1'b0;
            op_err_r <= 1'b0;
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= '0;
            mem_wdata_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            esize_r <= esize_nxt;
            pmode_r <= pmode_nxt;
            gov_r <= gov_nxt;
            src_a_r <= src_a_nxt;
            src_b_r <= src_b_nxt;
            dst_r <= dst_nxt;
            res_r <= res_nxt;
            buf_r <= buf_nxt;
            base_r <= base_nxt;
            elem_r <= elem_nxt;
            first_elem_r <= first_nxt;
            last_elem_r <= last_nxt;
            any_active_r <= any_nxt;
            op_ready_r <= ready_nxt;
            op_done_r <= done_nxt;
            op_err_r <= err_nxt;
            mem_req_r <= req_nxt;
            mem_we_r <= we_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_wdata_r <= wdata_nxt;
        end
    end
endmodule // vpl_lane_logic

// [rtl/vpl_pkg.sv]
// shared constants and types for the vector predicate lane logic
// assumes one core clock; issue logic and memory port share it
package vpl_pkg;
    localparam int GRANULE_BITS = 128;
    localparam int MIN_VL_BITS = 128;
    localparam int MAX_VL_BITS = 2048;
    localparam int NUM_VREGS = 32;
    localparam int NUM_PREGS = 16;
    localparam int NUM_GOV_PREGS = 8;
    localparam int VREG_IDX_W = 5;
    localparam int PREG_IDX_W = 4;
    localparam int LEN_W = 4;
    localparam int LEVEL_W = 2;
    localparam int ADDR_W = 64;
    localparam int ELEM_MAX_BITS = 128;
    localparam logic [1:0] LEVEL2 = 2'h2;
    localparam logic [1:0] LEVEL3 = 2'h3;

    // encoding order equals log2 of the element size in bytes
    typedef enum logic [2:0] {ES_B8, ES_H16, ES_S32, ES_D64, ES_Q128} vpl_esize_t;
    typedef enum logic [1:0] {PM_NONE, PM_MERGE, PM_ZERO} vpl_pmode_t;
    typedef enum logic [1:0] {OP_VEC, OP_PRED, OP_GATHER, OP_SCATTER} vpl_op_t;

    function automatic int esize_shift(input vpl_esize_t es);
        return int'(es);
    endfunction
endpackage

// [rtl/vpl_lane_mask.sv]
// per-byte lane mask and first/last active element finder
// assumes a stable predicate, element size and length on its inputs
module vpl_lane_mask #(
    parameter int MAX_VL = vpl_pkg::MAX_VL_BITS
) (
    input wire logic [MAX_VL/8-1:0] gov_pred,
    input wire vpl_pkg::vpl_esize_t esize,
    input wire logic [$clog2(MAX_VL/8+1)-1:0] vl_bytes,
    input wire logic unpredicated,
    output logic [MAX_VL/8-1:0] byte_mask,
    output logic [MAX_VL/8-1:0] elem_base,
    output logic [$clog2(MAX_VL/8)-1:0] first_elem,
    output logic [$clog2(MAX_VL/8)-1:0] last_elem,
    output logic any_active
);
    localparam int VB = MAX_VL / 8;
    localparam int IW = $clog2(VB);

    always_comb
    begin
        int sh;
        int lo;
        lo = 0;
        sh = vpl_pkg::esize_shift(esize);
        byte_mask = '0;
        elem_base = '0;
        first_elem = '0;
        last_elem = '0;
        any_active = 1'b0;
        for (int b = 0; b < VB; b++)
        begin
            lo = (b >> sh) << sh;
            if (b < int'(vl_bytes))
            begin
                byte_mask[b] = unpredicated | gov_pred[lo]; // RL5 RL9 RL10 RL22
                elem_base[b] = (b == lo); // RL4
            end
        end
        // highest index first so the lowest active base wins
        for (int b = VB - 1; b >= 0; b--)
        begin
            if (byte_mask[b] && elem_base[b])
            begin
                first_elem = IW'(b >> sh); // RL13
                any_active = 1'b1;
            end
        end
        for (int b = 0; b < VB; b++)
        begin
            if (byte_mask[b] && elem_base[b])
            begin
                last_elem = IW'(b >> sh); // RL14
            end
        end
    end
endmodule // vpl_lane_mask

// [tb/vpl_lane_logic_properties.sv]
// checker bound into vpl_lane_logic
// assumes one clock and async active-low reset
module vpl_lane_checker #(
    parameter int MAX_VL = vpl_pkg::MAX_VL_BITS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [vpl_pkg::LEN_W-1:0] length_limit_level3,
    input wire logic [vpl_pkg::LEVEL_W-1:0] cur_level,
    input wire logic op_valid,
    input wire vpl_pkg::vpl_op_t op_kind,
    input wire vpl_pkg::vpl_pmode_t op_pmode,
    input wire logic [vpl_pkg::PREG_IDX_W-1:0] op_gov_idx,
    input wire logic mem_ack,
    input wire logic op_ready_r,
    input wire logic op_done_r,
    input wire logic op_err_r,
    input wire logic [$clog2(MAX_VL+1)-1:0] vector_length_r,
    input wire logic [$clog2(MAX_VL/8)-1:0] first_elem_r,
    input wire logic [$clog2(MAX_VL/8)-1:0] last_elem_r,
    input wire logic any_active_r,
    input wire logic mem_req_r,
    input wire logic mem_we_r,
    input wire logic [vpl_pkg::ADDR_W-1:0] mem_addr_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    int lim3;
    assign lim3 = (int'(length_limit_level3) + 1) * 128;
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_take(k);
        op_valid && op_ready_r && op_kind == k && (op_pmode == vpl_pkg::PM_NONE || !op_gov_idx[3]);
    endsequence
    sequence s_exec_done;
        !op_ready_r ##1 (op_done_r && op_ready_r);
    endsequence
    property p_vec_lat;
        s_take(vpl_pkg::OP_VEC) |=> s_exec_done;
    endproperty
    a_vec_lat: assert property (p_vec_lat) else $error("vector op late");
    property p_pred_lat;
        s_take(vpl_pkg::OP_PRED) |=> s_exec_done;
    endproperty
    a_pred_lat: assert property (p_pred_lat) else $error("predicate op late");
    property p_refuse;
        op_valid && op_ready_r && op_pmode != vpl_pkg::PM_NONE && op_gov_idx[3] |=> op_err_r && op_ready_r && !op_done_r;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad index taken");
    property p_err_pulse;
        op_err_r |=> !op_err_r;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error too long");
    property p_vl_grid;
        vector_length_r[6:0] == 7'h0 && vector_length_r >= 128 && vector_length_r <= MAX_VL;
    endproperty
    a_vl_grid: assert property (p_vl_grid) else $error("length off grid");
    // held level and limit for one edge, so the register has caught up
    property p_vl_lim;
        cur_level == vpl_pkg::LEVEL3 && $past(cur_level) == vpl_pkg::LEVEL3 && $stable(length_limit_level3)
            && $past(rst_b) |-> vector_length_r == (lim3 > MAX_VL ? MAX_VL : lim3);
    endproperty
    a_vl_lim: assert property (p_vl_lim) else $error("length over limit");
    property p_first_last;
        any_active_r |-> first_elem_r <= last_elem_r;
    endproperty
    a_first_last: assert property (p_first_last) else $error("first above last");
    property p_mem_hold;
        mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("request not held");
    property p_mem_drop;
        mem_req_r && mem_ack |=> !mem_req_r;
    endproperty
    a_mem_drop: assert property (p_mem_drop) else $error("request not dropped");
    property p_mem_busy;
        mem_req_r |-> !op_ready_r;
    endproperty
    a_mem_busy: assert property (p_mem_busy) else $error("request while idle");
endmodule // vpl_lane_checker

bind vpl_lane_logic vpl_lane_checker #(.MAX_VL(MAX_VL)) u_chk (.*);

// [tb/vpl_mem_model.sv]
// gather/scatter memory model, read data made from the address
// assumes requests held until ack
module vpl_mem_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [1:0] wait_cyc,
    input wire logic mem_req_r,
    input wire logic mem_we_r,
    input wire logic [63:0] mem_addr_r,
    input wire logic [127:0] mem_wdata_r,
    output logic mem_ack = 1'b0,
    output logic [127:0] mem_rdata = 128'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] wmem [logic [63:0]];
    logic [1:0] cnt = 2'h0;
    // data flipped after ack so a late sample cannot pass
    always @(posedge clock)
    begin
        #1;
        if (mem_ack)
        begin
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
            cnt = 2'h0;
        end
        else if (rst_b && mem_req_r && cnt == wait_cyc)
        begin
            mem_ack = 1'b1;
            if (mem_we_r)
                wmem[mem_addr_r] = mem_wdata_r;
            else
                mem_rdata = {~mem_addr_r, mem_addr_r};
        end
        else if (rst_b && mem_req_r)
            cnt = cnt + 2'h1;
    end
endmodule // vpl_mem_model

// [tb/tb_vpl_lane_logic.sv]
// bench for vpl_lane_logic, 256-bit length
// assumes memory model and checker alongside
module tb_vpl_lane_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [255:0] A = {64'h0D0C_0B0A_0908_0706, 64'h1122_3344_5566_7788, 64'hF0E1_D2C3_B4A5_9687,
        64'h0F1E_2D3C_4B5A_6978};
    localparam logic [255:0] B = {64'h18, 64'h10, 64'h8, 64'h0};
    localparam logic [31:0] PG = 32'h0101_0F02;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] lim1 = 4'hF;
    logic [3:0] lim2 = 4'hF;
    logic [3:0] lim3 = 4'h1;
    logic [1:0] level = 2'h3;
    logic valid = 1'b0;
    vpl_pkg::vpl_op_t kind = vpl_pkg::OP_VEC;
    vpl_pkg::vpl_esize_t esz = vpl_pkg::ES_B8;
    vpl_pkg::vpl_pmode_t pm = vpl_pkg::PM_NONE;
    logic [3:0] gov = 4'h0;
    logic destr = 1'b0;
    logic [4:0] dst = 5'h0;
    logic [255:0] res = 256'h0;
    logic [4:0] ra = 5'h0;
    logic [4:0] rb = 5'h0;
    logic [3:0] rp = 4'h0;
    logic [1:0] wait_cyc = 2'h0;
    logic mem_ack;
    logic [127:0] mem_rdata;
    logic op_ready_r, op_done_r, op_err_r, any_active_r, mem_req_r, mem_we_r;
    logic [8:0] vl;
    logic [4:0] first, last;
    logic [63:0] mem_addr_r;
    logic [127:0] mem_wdata_r;
    logic [255:0] rda, rdb;
    logic [31:0] rdp;
    logic err;
    logic [255:0] m;
    int errors = 0;
    int checked = 0;
    always #12.5 clock = ~clock;
    vpl_lane_logic #(.MAX_VL(256)) uut (.*, .length_limit_level1(lim1), .length_limit_level2(lim2),
        .length_limit_level3(lim3), .cur_level(level), .op_valid(valid), .op_kind(kind), .op_esize(esz),
        .op_pmode(pm), .op_gov_idx(gov), .op_destructive(destr), .op_src_a(5'h1), .op_src_b(5'h2),
        .op_dst(dst), .op_result(res), .op_base_addr(64'h1000), .rd_a_idx(ra), .rd_b_idx(rb), .rd_p_idx(rp),
        .vector_length_r(vl), .first_elem_r(first), .last_elem_r(last), .rd_a_data_r(rda),
        .rd_b_data_r(rdb), .rd_p_data_r(rdp));
    vpl_mem_model mem (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [255:0] s, input logic [255:0] e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // bit mask from each element's base predicate bit
    function automatic logic [255:0] bm(input logic [31:0] p, input int es);
        for (int b = 0; b < 256; b++)
            bm[b] = p[(b / 8) & ~((1 << es) - 1)];
    endfunction
    task automatic op(input vpl_pkg::vpl_op_t k, input vpl_pkg::vpl_esize_t e, input vpl_pkg::vpl_pmode_t p,
            input logic [3:0] g, input logic d, input logic [4:0] t, input logic [255:0] r);
        int n;
        kind = k;
        esz = e;
        pm = p;
        gov = g;
        destr = d;
        dst = t;
        res = r;
        valid = 1'b1;
        tick(1);
        valid = 1'b0;
        n = 0;
        while (op_done_r !== 1'b1 && op_err_r !== 1'b1 && n < 60)
        begin
            tick(1);
            n++;
        end
        if (n == 60)
            errors++;
        err = op_err_r;
    endtask
    task automatic rd(input logic [4:0] a, input logic [4:0] b, input logic [3:0] p);
        ra = a;
        rb = b;
        rp = p;
        tick(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_length;
        tick(2);
        chk(vl, 256);
        level = 2'h0;
        lim1 = 4'h0;
        tick(2);
        chk(vl, 128);
        level = 2'h2;
        lim2 = 4'h0;
        tick(2);
        chk(vl, 128);
        level = 2'h3;
        tick(2);
        chk(vl, 256);
    endtask
    task automatic t_write;
        op(vpl_pkg::OP_VEC, vpl_pkg::ES_B8, vpl_pkg::PM_NONE, 4'h9, 1'b0, 5'h1, A);
        chk(err, 0);
        op(vpl_pkg::OP_VEC, vpl_pkg::ES_Q128, vpl_pkg::PM_NONE, 4'h0, 1'b0, 5'h2, B);
        op(vpl_pkg::OP_PRED, vpl_pkg::ES_S32, vpl_pkg::PM_NONE, 4'h0, 1'b0, 5'h3, 256'hFFFF_FFFF);
        op(vpl_pkg::OP_PRED, vpl_pkg::ES_B8, vpl_pkg::PM_NONE, 4'h0, 1'b0, 5'h5, PG);
        rd(5'h1, 5'h2, 4'h3);
        chk(rda, A);
        chk(rdb, B);
        chk(rdp, 32'h1111_1111);
        rd(5'h1, 5'h2, 4'h5);
        chk(rdp, PG);
    endtask
    task automatic t_merge_zero;
        m = (~A & bm(PG, 3)) | (A & ~bm(PG, 3));
        op(vpl_pkg::OP_VEC, vpl_pkg::ES_D64, vpl_pkg::PM_MERGE, 4'h5, 1'b1, 5'h0, ~A);
        chk({any_active_r, first, last}, {1'b1, 5'h1, 5'h3});
        rd(5'h1, 5'h0, 4'h0);
        chk(rda, m);
        op(vpl_pkg::OP_VEC, vpl_pkg::ES_B8, vpl_pkg::PM_ZERO, 4'h5, 1'b0, 5'h6, ~A);
        chk({first, last}, {5'h1, 5'h18});
        rd(5'h6, 5'h1, 4'h0);
        chk(rda, ~A & bm(PG, 0));
        chk(rdb, m);
    endtask
    task automatic t_refuse;
        op(vpl_pkg::OP_VEC, vpl_pkg::ES_B8, vpl_pkg::PM_MERGE, 4'h9, 1'b0, 5'h6, A);
        chk({err, op_ready_r, op_done_r}, 3'h6);
        rd(5'h6, 5'h0, 4'h0);
        chk(rda, ~A & bm(PG, 0));
    endtask
    task automatic t_gather_scatter;
        wait_cyc = 2'h2;
        op(vpl_pkg::OP_GATHER, vpl_pkg::ES_D64, vpl_pkg::PM_ZERO, 4'h5, 1'b0, 5'h7, 256'h0);
        rd(5'h7, 5'h0, 4'h0);
        chk(rda, {64'h1018, 64'h1010, 64'h1008, 64'h0});
        wait_cyc = 2'h0;
        op(vpl_pkg::OP_SCATTER, vpl_pkg::ES_D64, vpl_pkg::PM_MERGE, 4'h5, 1'b0, 5'h0, 256'h0);
        chk(mem.wmem.exists(64'h1000), 0);
        for (int i = 1; i < 4; i++)
            chk(mem.wmem[64'h1000 + 8 * i][63:0], m[64 * i +: 64]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        tick(2);
        chk({op_ready_r, vl}, {1'b1, 9'h080});
        tick(2);
        rst_b = 1'b1;
        t_length;
        t_write;
        t_merge_zero;
        t_refuse;
        t_gather_scatter;
        end_sim;
    end
    initial
    begin
        #50000;
        errors++;
        end_sim;
    end
endmodule // tb_vpl_lane_logic
